// ### dbo_pkg.sv
// Shared types, timing defaults and decode helpers for the DDR3 burst/ODT link
package dbo_pkg;

	// ************************************************************
	// Link encodings
	// ************************************************************
	typedef enum logic [2:0]
	{
		CMD_NOP = 3'h0,
		CMD_DES = 3'h1,
		CMD_ACT = 3'h2,
		CMD_RD  = 3'h3,
		CMD_WR  = 3'h4,
		CMD_PRE = 3'h5,
		CMD_MRS = 3'h6,
		CMD_SRE = 3'h7
	} dbo_cmd_t;

	typedef enum logic [3:0]
	{
		OP_MRS = 4'h0,
		OP_ACT = 4'h1,
		OP_WR  = 4'h2,
		OP_RD  = 4'h3,
		OP_PRE = 4'h4,
		OP_PDE = 4'h5,
		OP_PDX = 4'h6,
		OP_SRE = 4'h7,
		OP_SRX = 4'h8
	} dbo_op_t;

	typedef enum logic [2:0]
	{
		PWR_ON = 3'h1,
		PWR_PD = 3'h2,
		PWR_SR = 3'h4
	} dbo_pwr_t;

	// Burst-length field of the mode register
	localparam logic [1:0] BLM_FIX8 = 2'h0;
	localparam logic [1:0] BLM_OTF  = 2'h1;
	localparam logic [1:0] BLM_FIX4 = 2'h2;
	localparam int         BLM_LSB  = 0;

	localparam logic [3:0] BEATS_BL8 = 4'h8;
	localparam logic [3:0] BEATS_BC4 = 4'h4;

	localparam int DQ_W    = 16;
	localparam int ADDR_W  = 6;
	localparam int BA_W    = 3;
	localparam int BANKS   = 8;
	localparam int LAT_W   = 6;
	localparam int CNT_W   = 16;

	// ************************************************************
	// Timing, in link clocks unless noted
	// ************************************************************
	localparam int CLK_PERIOD_PS  = 4000;
	localparam int LINK_PERIOD_PS = 64000;
	localparam int DEF_LINK_HALF  = LINK_PERIOD_PS / (2 * CLK_PERIOD_PS);
	localparam int DEF_CL         = 5;
	localparam int DEF_CWL        = 5;
	localparam int DEF_AL         = 0;
	localparam int DEF_ODTH4      = 4;
	localparam int DEF_ODTH8      = 6;
	localparam int DEF_TWTR       = 4;
	localparam int DEF_TWR        = 6;
	localparam int DEF_TXS        = 5;
	localparam int DEF_TXSDLL     = 512;

	// ************************************************************
	// Helpers
	// ************************************************************
	function automatic logic [3:0] dbo_burst_len(input logic [1:0] mode, input logic a12);
		logic [3:0] len;
		len = BEATS_BL8;
		if (mode == BLM_FIX4)
			len = BEATS_BC4;
		else if (mode == BLM_OTF && !a12)
			len = BEATS_BC4;
		return len;
	endfunction

	// Remaining ODT high clocks after one registering edge
	function automatic logic [3:0] dbo_odt_hold(input logic [3:0] hold, input logic first_hi,
		input logic wr_hi, input logic bl8, input logic [3:0] h4, input logic [3:0] h8);
		logic [3:0] nxt;
		nxt = (hold != 4'h0) ? hold - 4'h1 : 4'h0;
		if (first_hi && nxt < h4 - 4'h1)
			nxt = h4 - 4'h1;
		if (wr_hi && bl8 && nxt < h8 - 4'h1)
			nxt = h8 - 4'h1;
		else if (wr_hi && !bl8 && nxt < h4 - 4'h1)
			nxt = h4 - 4'h1;
		return nxt;
	endfunction

endpackage

// ### dbo_link_if.sv
// Pin-level link between controller end and memory end
`timescale 1ns/1ps
interface dbo_link_if;
	import dbo_pkg::*;

	logic              ck;
	logic              cke;
	dbo_cmd_t          cmd;
	logic [BA_W-1:0]   ba;
	logic [ADDR_W-1:0] addr;
	logic              a12;
	logic              odt;
	logic [DQ_W-1:0]   ctl_dq_o;
	logic              ctl_dq_oe;
	logic [DQ_W-1:0]   dev_dq_o;
	logic              dev_dq_oe;
	logic [DQ_W-1:0]   dq;

	// Resolved data wire; an undriven bus reads as zero
	assign dq = ctl_dq_oe ? ctl_dq_o : (dev_dq_oe ? dev_dq_o : '0);

	modport ctl (output ck, cke, cmd, ba, addr, a12, odt, ctl_dq_o, ctl_dq_oe, input dq);
	modport dev (input ck, cke, cmd, ba, addr, a12, odt, dq, output dev_dq_o, dev_dq_oe);
endinterface

// ### dbo_dev.sv
// Memory end: burst decode, latency placement, ODT hold tracking, power states
//
// Overview of operation
// - Mode 00, or 01 with A12 high: BL8
// - Mode 01 with A12 low: BC4
// - Mode 10: every access is BC4
// - In mode 01, each READ takes length from its A12
// - tWTR counts from edge after last beat
// - tWR counts from edge after last beat
// - ODT held ODTH4 after first high
// - WRITE with ODT holds ODTH4 or ODTH8
// - Hold measured from rise or WRITE to low
// - ODT low only after both holds end
// - After self-refresh exit: NOP, non-DLL, DLL
// - Power-down after ACT/NOP/DES/PRE, bank open
`timescale 1ns/1ps
module dbo_dev #(
	parameter int CL    = dbo_pkg::DEF_CL,
	parameter int CWL   = dbo_pkg::DEF_CWL,
	parameter int AL    = dbo_pkg::DEF_AL,
	parameter int ODTH4 = dbo_pkg::DEF_ODTH4,
	parameter int ODTH8 = dbo_pkg::DEF_ODTH8
)(
	input  wire logic        i_clk,
	input  wire logic        i_sys_rst,
	dbo_link_if.dev          link,
	output logic [1:0]       o_bl_mode,
	output logic             o_rtt_on,
	output logic             o_odt_viol,
	output dbo_pkg::dbo_pwr_t o_pwr_state,
	output logic             o_sync_ready
);
	import dbo_pkg::*;

	localparam int WL    = AL + CWL;
	localparam int RL    = AL + CL;
	localparam int TANPD = WL - 1;
	localparam int SW    = 2 + 3 + ADDR_W + 2 + DQ_W;

	// ************************************************************
	// Pin synchronisers and edge detect
	// ************************************************************
	logic [SW-1:0]     s1_q;
	logic [SW-1:0]     s2_q;
	logic              ck_s;
	logic              cke_s;
	logic [2:0]        cmd_raw;
	logic [ADDR_W-1:0] addr_s;
	logic              a12_s;
	logic              odt_s;
	logic [DQ_W-1:0]   dq_s;
	logic              ck_prev_q;
	logic              rise;
	logic              fall;
	dbo_cmd_t          cmd_s;

	always_ff @(posedge i_clk or posedge i_sys_rst)
		if (i_sys_rst)
		begin
			s1_q      <= '0;
			s2_q      <= '0;
			ck_prev_q <= 1'b0;
		end
		else
		begin
			s1_q      <= {link.ck, link.cke, link.cmd, link.addr, link.a12, link.odt, link.dq};
			s2_q      <= s1_q;
			ck_prev_q <= ck_s;
		end

	assign {ck_s, cke_s, cmd_raw, addr_s, a12_s, odt_s, dq_s} = s2_q;
	assign cmd_s = dbo_cmd_t'(cmd_raw);
	assign rise  = ck_s & ~ck_prev_q;
	assign fall  = ~ck_s & ck_prev_q;

	// ************************************************************
	// Mode, power state and command decode
	// ************************************************************
	logic [1:0]       mode_q;
	dbo_pwr_t         pwr_q;
	logic [LAT_W-1:0] anpd_q;
	logic             cmd_v;
	logic [3:0]       len;

	assign cmd_v = rise & cke_s & (pwr_q == PWR_ON);
	assign len   = dbo_burst_len(mode_q, a12_s);

	always_ff @(posedge i_clk or posedge i_sys_rst)
		if (i_sys_rst)
			mode_q <= BLM_FIX8;
		else if (cmd_v && cmd_s == CMD_MRS)
			mode_q <= addr_s[BLM_LSB +: 2];

	always_ff @(posedge i_clk or posedge i_sys_rst)
		if (i_sys_rst)
		begin
			pwr_q  <= PWR_ON;
			anpd_q <= '0;
		end
		else if (rise)
		begin
			if (anpd_q != '0)
				anpd_q <= anpd_q - 1'b1;
			case (pwr_q)
				PWR_ON:
					if (!cke_s)
						pwr_q <= (cmd_s == CMD_SRE) ? PWR_SR : PWR_PD;
				PWR_PD, PWR_SR:
					if (cke_s)
					begin
						pwr_q  <= PWR_ON;
						anpd_q <= LAT_W'(TANPD);
					end
				default:
					pwr_q <= PWR_ON;
			endcase
		end

	// ************************************************************
	// Write capture and read drive
	// ************************************************************
	logic [DQ_W-1:0]   mem [2**ADDR_W];
	logic [LAT_W-1:0]  wdly_q;
	logic [3:0]        wrem_q;
	logic [ADDR_W-1:0] wptr_q;
	logic [LAT_W-1:0]  rdly_q;
	logic [3:0]        rrem_q;
	logic [ADDR_W-1:0] rptr_q;
	logic              wr_en;
	logic [DQ_W-1:0]   dq_o_q;
	logic              dq_oe_q;

	assign wr_en = rise & (wdly_q <= LAT_W'(1)) & (wrem_q != 4'h0);

	always_ff @(posedge i_clk or posedge i_sys_rst)
		if (i_sys_rst)
		begin
			wdly_q <= '0;
			wrem_q <= '0;
			wptr_q <= '0;
		end
		else if (cmd_v && cmd_s == CMD_WR)
		begin
			wdly_q <= LAT_W'(WL);
			wrem_q <= len;
			wptr_q <= addr_s;
		end
		else if (rise)
		begin
			if (wdly_q != '0)
				wdly_q <= wdly_q - 1'b1;
			if (wr_en)
			begin
				wrem_q <= wrem_q - 4'h1;
				wptr_q <= wptr_q + 1'b1;
			end
		end

	always_ff @(posedge i_clk)
		if (wr_en)
			mem[wptr_q] <= dq_s;

	always_ff @(posedge i_clk or posedge i_sys_rst)
		if (i_sys_rst)
		begin
			rdly_q  <= '0;
			rrem_q  <= '0;
			rptr_q  <= '0;
			dq_o_q  <= '0;
			dq_oe_q <= 1'b0;
		end
		else if (cmd_v && cmd_s == CMD_RD)
		begin
			rdly_q <= LAT_W'(RL);
			rrem_q <= len;
			rptr_q <= addr_s;
		end
		else if (rise && rdly_q != '0)
			rdly_q <= rdly_q - 1'b1;
		else if (fall)
		begin
			dq_oe_q <= 1'b0;
			if (rdly_q <= LAT_W'(1) && rrem_q != 4'h0)
			begin
				dq_o_q  <= mem[rptr_q];
				dq_oe_q <= 1'b1;
				rptr_q  <= rptr_q + 1'b1;
				rrem_q  <= rrem_q - 4'h1;
			end
		end

	// ************************************************************
	// ODT hold tracking
	// ************************************************************
	logic       odt_q;
	logic [3:0] hold_q;

	always_ff @(posedge i_clk or posedge i_sys_rst)
		if (i_sys_rst)
		begin
			odt_q      <= 1'b0;
			hold_q     <= '0;
			o_odt_viol <= 1'b0;
		end
		else if (rise)
		begin
			odt_q  <= odt_s;
			hold_q <= dbo_odt_hold(hold_q, odt_s & ~odt_q, cmd_v & (cmd_s == CMD_WR) & odt_s,
				len == BEATS_BL8, 4'(ODTH4), 4'(ODTH8));
			if (!odt_s && hold_q != 4'h0)
				o_odt_viol <= 1'b1;
		end

	assign link.dev_dq_o  = dq_o_q;
	assign link.dev_dq_oe = dq_oe_q;
	assign o_bl_mode      = mode_q;
	assign o_rtt_on       = odt_q;
	assign o_pwr_state    = pwr_q;
	assign o_sync_ready   = (pwr_q == PWR_ON) && (anpd_q == '0);
endmodule

// ### dbo_ctl.sv
// Controller end: link clock, command pacing, write data, read capture, ODT
`timescale 1ns/1ps
module dbo_ctl #(
	parameter int CL        = dbo_pkg::DEF_CL,
	parameter int CWL       = dbo_pkg::DEF_CWL,
	parameter int AL        = dbo_pkg::DEF_AL,
	parameter int ODTH4     = dbo_pkg::DEF_ODTH4,
	parameter int ODTH8     = dbo_pkg::DEF_ODTH8,
	parameter int TWTR      = dbo_pkg::DEF_TWTR,
	parameter int TWR       = dbo_pkg::DEF_TWR,
	parameter int TXS       = dbo_pkg::DEF_TXS,
	parameter int TXSDLL    = dbo_pkg::DEF_TXSDLL,
	parameter int LINK_HALF = dbo_pkg::DEF_LINK_HALF
)(
	input  wire logic                       i_clk,
	input  wire logic                       i_sys_rst,
	dbo_link_if.ctl                         link,
	input  wire logic                       i_req_valid,
	input  wire dbo_pkg::dbo_op_t           i_req_op,
	input  wire logic [dbo_pkg::BA_W-1:0]   i_req_ba,
	input  wire logic [dbo_pkg::ADDR_W-1:0] i_req_addr,
	input  wire logic                       i_req_a12,
	input  wire logic [8*dbo_pkg::DQ_W-1:0] i_req_wdata,
	input  wire logic                       i_odt_req,
	output logic                            o_req_ready,
	output logic [dbo_pkg::DQ_W-1:0]        o_rdata,
	output logic                            o_rdata_valid,
	output dbo_pkg::dbo_pwr_t               o_pwr_state
);
	import dbo_pkg::*;

	localparam int WL    = AL + CWL;
	localparam int RL    = AL + CL;
	localparam int TANPD = WL - 1;

	// ************************************************************
	// Link clock divider
	// ************************************************************
	logic [CNT_W-1:0] div_q;
	logic             ck_q;
	logic             wrap;
	logic             rise_t;
	logic             fall_t;

	assign wrap   = div_q == CNT_W'(LINK_HALF - 1);
	assign rise_t = wrap & ~ck_q;
	assign fall_t = wrap & ck_q;

	always_ff @(posedge i_clk or posedge i_sys_rst)
		if (i_sys_rst)
		begin
			div_q <= '0;
			ck_q  <= 1'b0;
		end
		else
		begin
			div_q <= wrap ? '0 : div_q + 1'b1;
			if (wrap)
				ck_q <= ~ck_q;
		end

	// ************************************************************
	// Command acceptance
	// ************************************************************
	dbo_cmd_t          cmd_q;
	logic              cke_q;
	logic [BA_W-1:0]   ba_q;
	logic [ADDR_W-1:0] addr_q;
	logic              a12_q;
	dbo_pwr_t          pwr_q;
	logic [BANKS-1:0]  open_q;
	logic [1:0]        mode_q;
	logic [LAT_W-1:0]  wdly_q;
	logic [3:0]        wrem_q;
	logic [LAT_W-1:0]  rdly_q;
	logic [3:0]        rrem_q;
	logic              dq_oe_q;
	logic [CNT_W-1:0]  wtr_q;
	logic [CNT_W-1:0]  wr_q;
	logic [CNT_W-1:0]  xs_q;
	logic [CNT_W-1:0]  dll_q;
	logic [CNT_W-1:0]  anpd_q;
	logic              busy;
	logic              ok;
	logic              issue;
	logic [3:0]        len;
	logic              last_ok;

	assign busy    = (wdly_q != '0) | (wrem_q != 4'h0) | (rdly_q != '0) | (rrem_q != 4'h0) | dq_oe_q;
	assign len     = dbo_burst_len(mode_q, i_req_a12);
	assign last_ok = cmd_q inside {CMD_ACT, CMD_NOP, CMD_DES, CMD_PRE};

	always_comb
	begin
		ok = 1'b0;
		if (anpd_q == '0)
			case (pwr_q)
				PWR_PD:
					ok = i_req_op == OP_PDX;
				PWR_SR:
					ok = i_req_op == OP_SRX;
				PWR_ON:
					case (i_req_op)
						OP_RD:
							ok = !busy && wtr_q == '0 && xs_q == '0 && dll_q == '0;
						OP_WR:
							ok = !busy && xs_q == '0;
						OP_PRE:
							ok = !busy && wr_q == '0 && xs_q == '0;
						OP_PDE:
							ok = !busy && xs_q == '0 && last_ok && open_q != '0;
						OP_SRE:
							ok = !busy && xs_q == '0 && open_q == '0;
						OP_MRS, OP_ACT:
							ok = xs_q == '0;
						default:
							ok = 1'b0;
					endcase
				default:
					ok = 1'b0;
			endcase
	end

	assign o_req_ready = fall_t & i_req_valid & ok;
	assign issue       = o_req_ready;

	always_ff @(posedge i_clk or posedge i_sys_rst)
		if (i_sys_rst)
		begin
			cmd_q  <= CMD_NOP;
			cke_q  <= 1'b1;
			ba_q   <= '0;
			addr_q <= '0;
			a12_q  <= 1'b0;
		end
		else if (fall_t)
		begin
			cmd_q <= CMD_NOP;
			if (issue)
			begin
				ba_q   <= i_req_ba;
				addr_q <= i_req_addr;
				a12_q  <= i_req_a12;
				case (i_req_op)
					OP_MRS: cmd_q <= CMD_MRS;
					OP_ACT: cmd_q <= CMD_ACT;
					OP_WR:  cmd_q <= CMD_WR;
					OP_RD:  cmd_q <= CMD_RD;
					OP_PRE: cmd_q <= CMD_PRE;
					OP_SRE:
					begin
						cmd_q <= CMD_SRE;
						cke_q <= 1'b0;
					end
					OP_PDE: cke_q <= 1'b0;
					default: cke_q <= 1'b1;
				endcase
			end
		end

	always_ff @(posedge i_clk or posedge i_sys_rst)
		if (i_sys_rst)
		begin
			pwr_q  <= PWR_ON;
			open_q <= '0;
			mode_q <= BLM_FIX8;
		end
		else if (issue)
			case (i_req_op)
				OP_MRS:  mode_q <= i_req_addr[BLM_LSB +: 2];
				OP_ACT:  open_q[i_req_ba] <= 1'b1;
				OP_PRE:  open_q[i_req_ba] <= 1'b0;
				OP_PDE:  pwr_q <= PWR_PD;
				OP_SRE:  pwr_q <= PWR_SR;
				OP_PDX, OP_SRX: pwr_q <= PWR_ON;
				default: pwr_q <= pwr_q;
			endcase

	// ************************************************************
	// Exit and recovery timers
	// ************************************************************
	always_ff @(posedge i_clk or posedge i_sys_rst)
		if (i_sys_rst)
		begin
			xs_q   <= '0;
			dll_q  <= '0;
			anpd_q <= '0;
		end
		else if (issue && i_req_op == OP_SRX)
		begin
			xs_q   <= CNT_W'(TXS);
			dll_q  <= CNT_W'(TXSDLL);
			anpd_q <= CNT_W'(TANPD);
		end
		else if (issue && i_req_op == OP_PDX)
			anpd_q <= CNT_W'(TANPD);
		else if (rise_t)
		begin
			if (xs_q != '0)
				xs_q <= xs_q - 1'b1;
			if (dll_q != '0)
				dll_q <= dll_q - 1'b1;
			if (anpd_q != '0)
				anpd_q <= anpd_q - 1'b1;
		end

	always_ff @(posedge i_clk or posedge i_sys_rst)
		if (i_sys_rst)
		begin
			wtr_q <= '0;
			wr_q  <= '0;
		end
		else if (rise_t)
		begin
			if (dq_oe_q && wrem_q == 4'h0)
			begin
				wtr_q <= CNT_W'(TWTR);
				wr_q  <= CNT_W'(TWR);
			end
			else
			begin
				if (wtr_q != '0)
					wtr_q <= wtr_q - 1'b1;
				if (wr_q != '0)
					wr_q <= wr_q - 1'b1;
			end
		end

	// ************************************************************
	// Write data drive and read data capture
	// ************************************************************
	logic [8*DQ_W-1:0] wbuf_q;
	logic [2:0]        beat_q;
	logic [DQ_W-1:0]   dq_o_q;
	logic [DQ_W-1:0]   dq1_q;
	logic [DQ_W-1:0]   dq2_q;

	always_ff @(posedge i_clk or posedge i_sys_rst)
		if (i_sys_rst)
		begin
			wdly_q  <= '0;
			wrem_q  <= '0;
			wbuf_q  <= '0;
			beat_q  <= '0;
			dq_o_q  <= '0;
			dq_oe_q <= 1'b0;
		end
		else if (issue && i_req_op == OP_WR)
		begin
			wdly_q <= LAT_W'(WL + 1);
			wrem_q <= len;
			wbuf_q <= i_req_wdata;
			beat_q <= '0;
		end
		else if (rise_t && wdly_q != '0)
			wdly_q <= wdly_q - 1'b1;
		else if (fall_t)
		begin
			dq_oe_q <= 1'b0;
			if (wdly_q <= LAT_W'(1) && wrem_q != 4'h0)
			begin
				dq_o_q  <= wbuf_q[beat_q*DQ_W +: DQ_W];
				dq_oe_q <= 1'b1;
				beat_q  <= beat_q + 1'b1;
				wrem_q  <= wrem_q - 4'h1;
			end
		end

	always_ff @(posedge i_clk or posedge i_sys_rst)
		if (i_sys_rst)
		begin
			dq1_q         <= '0;
			dq2_q         <= '0;
			rdly_q        <= '0;
			rrem_q        <= '0;
			o_rdata       <= '0;
			o_rdata_valid <= 1'b0;
		end
		else
		begin
			dq1_q         <= link.dq;
			dq2_q         <= dq1_q;
			o_rdata_valid <= 1'b0;
			if (issue && i_req_op == OP_RD)
			begin
				rdly_q <= LAT_W'(RL + 1);
				rrem_q <= len;
			end
			else if (rise_t)
			begin
				if (rdly_q != '0)
					rdly_q <= rdly_q - 1'b1;
				if (rdly_q <= LAT_W'(1) && rrem_q != 4'h0)
				begin
					o_rdata       <= dq2_q;
					o_rdata_valid <= 1'b1;
					rrem_q        <= rrem_q - 4'h1;
				end
			end
		end

	// ************************************************************
	// ODT with hold
	// ************************************************************
	logic       odt_q;
	logic       odt_reg_q;
	logic [3:0] hold_q;
	logic [3:0] wr_len_q;

	always_ff @(posedge i_clk or posedge i_sys_rst)
		if (i_sys_rst)
			wr_len_q <= BEATS_BL8;
		else if (issue && i_req_op == OP_WR)
			wr_len_q <= len;

	always_ff @(posedge i_clk or posedge i_sys_rst)
		if (i_sys_rst)
		begin
			odt_q     <= 1'b0;
			odt_reg_q <= 1'b0;
			hold_q    <= '0;
		end
		else if (rise_t)
		begin
			odt_reg_q <= odt_q;
			hold_q    <= dbo_odt_hold(hold_q, odt_q & ~odt_reg_q, (cmd_q == CMD_WR) & odt_q,
				wr_len_q == BEATS_BL8, 4'(ODTH4), 4'(ODTH8));
		end
		else if (fall_t)
			odt_q <= i_odt_req | (hold_q != 4'h0);

	assign link.ck        = ck_q;
	assign link.cke       = cke_q;
	assign link.cmd       = cmd_q;
	assign link.ba        = ba_q;
	assign link.addr      = addr_q;
	assign link.a12       = a12_q;
	assign link.odt       = odt_q;
	assign link.ctl_dq_o  = dq_o_q;
	assign link.ctl_dq_oe = dq_oe_q;
	assign o_pwr_state    = pwr_q;
endmodule

// ### dbo_link_monitor.sv
// Link checker: burst length, latencies, ODT hold and command spacing
`timescale 1ns/1ps
module dbo_link_monitor #(
	parameter int LINK_HALF = 8,
	parameter int CL        = 5,
	parameter int CWL       = 5,
	parameter int AL        = 0,
	parameter int ODTH4     = 4,
	parameter int TWTR      = 4,
	parameter int TWR       = 6
)(
	input wire logic              i_clk,
	input wire logic              i_sys_rst,
	input wire logic              ck,
	input wire logic              cke,
	input wire dbo_pkg::dbo_cmd_t cmd,
	input wire logic              odt,
	input wire logic              ctl_dq_oe,
	input wire logic              dev_dq_oe
);
	import dbo_pkg::*;
	localparam int LP    = 2 * LINK_HALF;
	localparam int WL_LO = LP * (AL + CWL - 1) + LINK_HALF - 3;
	localparam int WL_HI = WL_LO + 6;
	localparam int RL_LO = LP * (AL + CL - 1) + LINK_HALF - 3;
	localparam int RL_HI = RL_LO + 12;
	logic        ck_q;
	logic        rise;
	logic [11:0] oe_q, gap_q, odt_q, wodt_q, cke_q;
	dbo_cmd_t    last_q;

	function automatic logic [11:0] inc(input logic [11:0] v);
		return (v == 12'hfff) ? v : v + 12'h001;
	endfunction

	assign rise = ck && !ck_q;

	// Cycle counters since the events that the spacing checks measure from
	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			ck_q   <= 1'b0;
			oe_q   <= 12'h000;
			gap_q  <= 12'hfff;
			odt_q  <= 12'h000;
			wodt_q <= 12'hfff;
			cke_q  <= 12'hfff;
			last_q <= CMD_NOP;
		end
		else
		begin
			ck_q   <= ck;
			oe_q   <= ctl_dq_oe ? inc(oe_q) : 12'h000;
			gap_q  <= ctl_dq_oe ? 12'h000 : inc(gap_q);
			odt_q  <= odt ? inc(odt_q) : 12'h000;
			wodt_q <= (rise && odt && cmd == CMD_WR) ? 12'h000 : inc(wodt_q);
			cke_q  <= cke ? inc(cke_q) : 12'h000;
			if (rise)
				last_q <= cmd;
		end
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_sys_rst);

	wr_burst_len_a:
		assert property ($fell(ctl_dq_oe) |-> oe_q inside {[LP*4-1:LP*4+1], [LP*8-1:LP*8+1]})
		else $error("write burst length wrong");
	wr_latency_a:
		assert property (rise && cmd == CMD_WR |-> ##[WL_LO:WL_HI] $rose(ctl_dq_oe))
		else $error("write data off latency");
	rd_latency_a:
		assert property (rise && cmd == CMD_RD |-> ##[RL_LO:RL_HI] $rose(dev_dq_oe))
		else $error("read data off latency");
	odt_hold_a:
		assert property ($fell(odt) |-> odt_q >= 12'(LP * ODTH4 - 4))
		else $error("termination dropped early");
	odt_write_hold_a:
		assert property ($fell(odt) |-> wodt_q >= 12'(LP * (ODTH4 - 1) + LINK_HALF - 4))
		else $error("termination dropped early after write");
	wtr_spacing_a:
		assert property (rise && cmd == CMD_RD |-> gap_q >= 12'(LP * TWTR + LINK_HALF - 4))
		else $error("read too soon after write");
	wr_recovery_a:
		assert property (rise && cmd == CMD_PRE |-> gap_q >= 12'(LP * TWR + LINK_HALF - 4))
		else $error("precharge too soon after write");
	pd_entry_a:
		assert property ($fell(cke) && cmd == CMD_NOP |-> last_q inside {CMD_ACT, CMD_NOP, CMD_DES, CMD_PRE})
		else $error("bad command before power-down");
	exit_quiet_a:
		assert property (rise && cke && !(cmd inside {CMD_NOP, CMD_DES}) |-> cke_q >= 12'(LP * (AL + CWL - 1) - 4))
		else $error("command too soon after exit");

	wr_seen_c: cover property (rise && cmd == CMD_WR);
	rd_seen_c: cover property (rise && cmd == CMD_RD);
	pd_seen_c: cover property ($fell(cke) && cmd == CMD_NOP);
endmodule

// ### testbench.sv
// Bench joining controller and memory ends with random and corner traffic
`timescale 1ns/1ps
module testbench;
	import dbo_pkg::*;
	localparam int LH = DEF_LINK_HALF;
	logic              i_clk;
	logic              i_sys_rst;
	logic              req_valid;
	dbo_op_t           req_op;
	logic [ADDR_W-1:0] req_addr;
	logic              req_a12;
	logic [8*DQ_W-1:0] req_wdata;
	logic              odt_req;
	logic              req_ready;
	logic [DQ_W-1:0]   rdata;
	logic              rdata_valid;
	dbo_pwr_t          dev_pwr;
	dbo_pwr_t          ctl_pwr;
	logic              rtt_on;
	logic [1:0]        bl_mode;
	logic              odt_viol;
	logic              sync_ready;
	logic [31:0]       rng;
	logic [DQ_W-1:0]   mem [64];
	logic              known [64];
	logic [DQ_W-1:0]   beats [$];
	int                mismatches;
	int                n_compared;
	int                cyc;

	dbo_link_if link ();
	dbo_ctl #(.TXSDLL(8), .LINK_HALF(LH)) i_dbo_ctl (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .link(link.ctl),
		.i_req_valid(req_valid), .i_req_op(req_op), .i_req_ba(3'h1), .i_req_addr(req_addr), .i_req_a12(req_a12),
		.i_req_wdata(req_wdata), .i_odt_req(odt_req), .o_req_ready(req_ready), .o_rdata(rdata),
		.o_rdata_valid(rdata_valid), .o_pwr_state(ctl_pwr));
	dbo_dev i_dbo_dev (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .link(link.dev), .o_bl_mode(bl_mode),
		.o_rtt_on(rtt_on), .o_odt_viol(odt_viol), .o_pwr_state(dev_pwr), .o_sync_ready(sync_ready));
	dbo_link_monitor #(.LINK_HALF(LH)) i_dbo_link_monitor (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .ck(link.ck),
		.cke(link.cke), .cmd(link.cmd), .odt(link.odt), .ctl_dq_oe(link.ctl_dq_oe), .dev_dq_oe(link.dev_dq_oe));

	initial
	begin
		i_clk = 1'b0;
		forever #2 i_clk = ~i_clk;
	end

	// Read beat capture and hang limit
	always @(posedge i_clk)
	begin
		cyc++;
		if (rdata_valid === 1'b1)
			beats.push_back(rdata);
		if (cyc == 90000)
		begin
			mismatches++;
			end_sim();
		end
	end

	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	function automatic int exp_len(input logic [1:0] md, input logic a12);
		return (md == 2'h2 || (md == 2'h1 && !a12)) ? 4 : 8;
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] want);
		n_compared++;
		if (got !== want)
		begin
			mismatches++;
			$display("[ERR] %0t got %0h expected %0h", $time, got, want);
		end
	endtask

	task automatic wait_cyc(input int k);
		repeat (k) @(posedge i_clk);
		#1;
	endtask

	task automatic req(input dbo_op_t op, input logic [5:0] ad, input logic a, input int lim, input logic want);
		int n;
		logic took;
		n = 0;
		took = 1'b0;
		req_op = op;
		req_addr = ad;
		req_a12 = a;
		req_valid = 1'b1;
		while (!took && n < lim)
		begin
			@(negedge i_clk);
			took = (req_ready === 1'b1);
			n++;
			@(posedge i_clk);
			#1;
		end
		req_valid = 1'b0;
		wait_cyc(1);
		chk(took, want);
	endtask

	task automatic wr_rd(input logic [1:0] md, input logic [5:0] col, input logic wa, input logic ra);
		logic [8*DQ_W-1:0] wd;
		int k;
		int rl;
		for (k = 0; k < 4; k++)
		begin
			rng = xs(rng);
			wd[32*k+:32] = rng;
		end
		req_wdata = wd;
		odt_req = rng[3];
		req(OP_WR, col, wa, 400, 1'b1);
		for (k = 0; k < exp_len(md, wa); k++)
		begin
			mem[col + 6'(k)] = wd[16*k+:16];
			known[col + 6'(k)] = 1'b1;
		end
		odt_req = 1'b0;
		beats.delete();
		req(OP_RD, col, ra, 800, 1'b1);
		rl = exp_len(md, ra);
		k = 0;
		while (beats.size() < rl && k < 400)
		begin
			wait_cyc(1);
			k++;
		end
		wait_cyc(4 * LH);
		chk(beats.size(), rl);
		for (k = 0; k < rl && k < beats.size(); k++)
			if (known[col + 6'(k)])
				chk(beats[k], mem[col + 6'(k)]);
	endtask

	task automatic end_sim();
		if (mismatches == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial
	begin
		int m;
		int j;
		int n;
		i_sys_rst = 1'b1;
		req_valid = 1'b0;
		req_op = OP_MRS;
		req_addr = 6'h00;
		req_a12 = 1'b0;
		req_wdata = '0;
		odt_req = 1'b0;
		rng = 32'h0000_0011;
		mismatches = 0;
		n_compared = 0;
		cyc = 0;
		foreach (known[k])
			known[k] = 1'b0;
		repeat (8) @(posedge i_clk);
		#1;
		i_sys_rst = 1'b0;
		chk(bl_mode, BLM_FIX8);
		req(OP_ACT, 6'h00, 1'b0, 400, 1'b1);
		for (m = 0; m < 4; m++)
		begin
			req(OP_MRS, 6'(m), 1'b0, 400, 1'b1);
			wait_cyc(4 * LH);
			chk(bl_mode, m[1:0]);
			for (j = 0; j < 4; j++)
			begin
				rng = xs(rng);
				wr_rd(m[1:0], (j == 0) ? 6'h3e : rng[5:0], j[1], j[0]);
			end
		end
		// Precharge straight after a burst write must wait out write recovery
		req(OP_WR, 6'h00, 1'b1, 400, 1'b1);
		n = cyc;
		req(OP_PRE, 6'h00, 1'b0, 400, 1'b1);
		chk(cyc - n >= 2 * LH * (DEF_AL + DEF_CWL + 8 + DEF_TWR) - 4, 1'b1);
		req(OP_ACT, 6'h00, 1'b0, 400, 1'b1);
		// Lone termination request of one link clock must still be held
		odt_req = 1'b1;
		wait_cyc(2 * LH);
		odt_req = 1'b0;
		wait_cyc(2 * LH);
		chk(rtt_on, 1'b1);
		wait_cyc(12 * LH);
		req(OP_PDE, 6'h00, 1'b0, 400, 1'b1);
		wait_cyc(8 * LH);
		chk(dev_pwr, PWR_PD);
		chk(ctl_pwr, PWR_PD);
		req(OP_PDX, 6'h00, 1'b0, 400, 1'b1);
		n = 0;
		while (sync_ready !== 1'b1 && n < 400)
		begin
			wait_cyc(1);
			n++;
		end
		chk(n >= 2 * LH * (DEF_AL + DEF_CWL - 1) - 2 && n < 400, 1'b1);
		req(OP_PRE, 6'h00, 1'b0, 400, 1'b1);
		req(OP_PDE, 6'h00, 1'b0, 300, 1'b0);
		req(OP_SRE, 6'h00, 1'b0, 400, 1'b1);
		wait_cyc(8 * LH);
		chk(dev_pwr, PWR_SR);
		chk(ctl_pwr, PWR_SR);
		req(OP_SRX, 6'h00, 1'b0, 400, 1'b1);
		n = cyc;
		req(OP_ACT, 6'h00, 1'b0, 400, 1'b1);
		req(OP_RD, 6'h00, 1'b1, 2000, 1'b1);
		chk(cyc - n >= 2 * LH * 8 - 4, 1'b1);
		wait_cyc(40 * LH);
		chk(odt_viol, 1'b0);
		end_sim();
	end
endmodule
